// ### ewc_pkg.sv
// Constants and types for the external area wait and idle configuration block
package ewc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_UPPER_WAIT  = 8'h00;
    localparam logic [7:0] OFF_LOWER_WAIT  = 8'h04;
    localparam logic [7:0] OFF_IDLE_CTRL   = 8'h08;
    localparam logic [7:0] OFF_ACC_STATE   = 8'h0C;
    localparam logic [7:0] OFF_STATUS      = 8'h10;

    // Values after power-on reset or hardware standby
    localparam logic [7:0] RST_UPPER_WAIT  = 8'hFF;
    localparam logic [7:0] RST_LOWER_WAIT  = 8'hFF;
    localparam logic [7:0] RST_IDLE_CTRL   = 8'hD0;
    localparam logic [7:0] RST_ACC_STATE   = 8'hFF;

    // Idle and area-0 interface control fields
    localparam int         RR_IDLE_BIT     = 7;
    localparam int         RW_IDLE_BIT     = 6;
    localparam int         BROM_SEL_BIT    = 5;
    localparam int         BCYC_LEN_BIT    = 4;
    localparam int         BWORD_CNT_BIT   = 3;
    localparam logic [7:0] IDLE_CTRL_MASK  = 8'hF8;

    // Status register fields
    localparam int         STAT_BUSY_BIT   = 0;
    localparam int         STAT_AREA_LSB   = 1;
    localparam int         STAT_PREVRD_BIT = 4;
    localparam int         STAT_WAIT_LSB   = 5;
    localparam int         STAT_GAP_BIT    = 7;

    // Access lengths in states, stored minus one
    localparam logic [1:0] BASE_TWO_M1     = 2'h1;
    localparam logic [1:0] BASE_THREE_M1   = 2'h2;
    localparam logic [1:0] BASE_ONE_M1     = 2'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        ST_READY  = 2'b00,
        ST_GAP    = 2'b01,
        ST_ACCESS = 2'b11,
        ST_WAIT   = 2'b10
    } ewc_state_e;

endpackage

// ### ewc_top.sv
// External area wait state, idle cycle and area-0 interface control with AXI4-Lite registers
//
// Contract
// [R1] Two-bit wait field gives zero to three waits
// [R2] Upper register holds areas 7 to 4
// [R3] Lower register holds areas 3 to 0
// [R4] Waits only for external three-state area accesses
// [R5] Both wait registers reset to all ones
// [R6] Idle control loads 0xD0 on reset, hardware standby
// [R7] Idle control kept through manual reset, software standby
// [R8] Bit 7 inserts idle between reads, different areas
// [R9] Bit 6 selects idle between read then write
// [R10] Read-write idle bit defaults set, clear removes it
// [R11] Bit 5 selects burst ROM for area 0
// [R12] Bits 4,3 set burst cycle and word count
// [R13] Software writes zeros to reserved low bits
// [R14] Extend access by exactly the selected states
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ewc_top
    import ewc_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // Mode pins
    input  wire logic        HW_STANDBY_N,
    input  wire logic        MANUAL_RESET,
    input  wire logic        SW_STANDBY,
    // AXI4-Lite write address
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic [2:0]  S_AXI_AWPROT,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic [2:0]  S_AXI_ARPROT,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Internal bus master access request
    input  wire logic        ACC_VALID,
    output logic             ACC_READY,
    input  wire logic [2:0]  ACC_AREA,
    input  wire logic        ACC_WRITE,
    input  wire logic        ACC_EXTERNAL,
    output logic             ACC_DONE,
    // Bus cycle state
    output logic             IDLE_STATE,
    output logic             WAIT_STATE,
    // Area-0 interface selection
    output logic             BURST_ROM_SEL,
    output logic             BURST_CYCLE_TWO,
    output logic             BURST_EIGHT_WORDS
);

    // Synchronisers for pins
    logic       stby_meta_reg;
    logic       stby_sync_reg;
    logic       mrst_meta_reg;
    logic       mrst_sync_reg;
    logic       sstby_meta_reg;
    logic       sstby_sync_reg;

    // Configuration registers
    logic [7:0] upper_area_wait_count_reg;
    logic [7:0] lower_area_wait_count_reg;
    logic [7:0] idle_and_area0_interface_control_reg;
    logic [7:0] access_state_select_register_reg;

    // AXI slave state
    logic       aw_hold_reg;
    logic [7:0] aw_addr_reg;
    logic       w_hold_reg;
    logic [7:0] w_data_reg;
    logic       w_strb0_reg;
    logic       bvalid_reg;
    logic [1:0] bresp_reg;
    logic       rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic       do_write;
    logic       wr_hit;
    logic       rd_take;
    logic [7:0] rd_word;
    logic       rd_hit;

    // Access sequencer
    ewc_state_e state_reg;
    logic [1:0] cnt_reg;
    logic [2:0] cur_area_reg;
    logic       cur_write_reg;
    logic       cur_ext_reg;
    logic       prev_ext_read_reg;
    logic [2:0] prev_area_reg;
    logic       done_reg;
    logic       hw_init;
    logic       seq_abort;
    logic       acc_take;
    logic       need_gap;
    logic       read_read_idle_insert;
    logic       read_write_idle_insert;
    logic       area0_burst_rom_select;
    logic       burst_cycle_length_select;
    logic       burst_word_count_select;
    logic [1:0] cur_waits;

    // Two flops before any logic sees a pin
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            {stby_meta_reg, mrst_meta_reg, sstby_meta_reg} <= 3'h4;
            {stby_sync_reg, mrst_sync_reg, sstby_sync_reg} <= 3'h4;
        end else begin
            {stby_meta_reg, mrst_meta_reg, sstby_meta_reg} <= {HW_STANDBY_N, MANUAL_RESET, SW_STANDBY};
            {stby_sync_reg, mrst_sync_reg, sstby_sync_reg} <= {stby_meta_reg, mrst_meta_reg, sstby_meta_reg};
        end
    end

    // Power-on reset and hardware standby both reinitialise
    assign hw_init   = RESET | ~stby_sync_reg;
    // Manual reset and software standby stop bus cycles only
    assign seq_abort = hw_init | mrst_sync_reg | sstby_sync_reg;

    assign read_read_idle_insert     = idle_and_area0_interface_control_reg[RR_IDLE_BIT];
    assign read_write_idle_insert    = idle_and_area0_interface_control_reg[RW_IDLE_BIT];
    assign area0_burst_rom_select    = idle_and_area0_interface_control_reg[BROM_SEL_BIT];
    assign burst_cycle_length_select = idle_and_area0_interface_control_reg[BCYC_LEN_BIT];
    assign burst_word_count_select   = idle_and_area0_interface_control_reg[BWORD_CNT_BIT];

    // Field of one area from the two wait registers
    function automatic logic [1:0] area_field(input logic [2:0] area, input logic [7:0] upper,
                                              input logic [7:0] lower);
        logic [7:0] sel;
        sel = area[2] ? upper : lower;
        area_field = sel[{area[1:0], 1'b0} +: 2]; // R2 R3
    endfunction

    // Program waits for an access, none unless external three-state
    function automatic logic [1:0] waits_for(input logic [2:0] area, input logic ext, input logic ast,
                                             input logic brom, input logic [1:0] field);
        waits_for = (ext && ast && !(brom && area == 3'h0)) ? field : 2'h0; // R1 R4
    endfunction

    // Basic access states minus one
    function automatic logic [1:0] base_for(input logic [2:0] area, input logic ext, input logic ast,
                                            input logic brom, input logic two);
        base_for = !ext ? BASE_ONE_M1 :
                   (brom && area == 3'h0) ? (two ? BASE_TWO_M1 : BASE_ONE_M1) : // R12
                   ast ? BASE_THREE_M1 : BASE_TWO_M1;
    endfunction

    assign cur_waits = waits_for(cur_area_reg, cur_ext_reg, access_state_select_register_reg[cur_area_reg],
                                 area0_burst_rom_select,
                                 area_field(cur_area_reg, upper_area_wait_count_reg, lower_area_wait_count_reg));

    // Idle state only after an external read
    assign need_gap = ACC_EXTERNAL && prev_ext_read_reg &&
                      ((!ACC_WRITE && ACC_AREA != prev_area_reg && read_read_idle_insert) || // R8
                       (ACC_WRITE && read_write_idle_insert)); // R9 R10

    assign ACC_READY = (state_reg == ST_READY) && !seq_abort;
    assign acc_take  = ACC_VALID && ACC_READY;

    always_ff @(posedge MCLK) begin
        if (seq_abort) begin
            state_reg         <= ST_READY;
            cnt_reg           <= 2'h0;
            cur_area_reg      <= 3'h0;
            cur_write_reg     <= 1'b0;
            cur_ext_reg       <= 1'b0;
            prev_ext_read_reg <= 1'b0;
            prev_area_reg     <= 3'h0;
            done_reg          <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                ST_READY: begin
                    if (acc_take) begin
                        cur_area_reg  <= ACC_AREA;
                        cur_write_reg <= ACC_WRITE;
                        cur_ext_reg   <= ACC_EXTERNAL;
                        if (need_gap) begin
                            state_reg <= ST_GAP;
                        end else begin
                            state_reg <= ST_ACCESS;
                            cnt_reg   <= base_for(ACC_AREA, ACC_EXTERNAL,
                                                  access_state_select_register_reg[ACC_AREA],
                                                  area0_burst_rom_select, burst_cycle_length_select);
                        end
                    end
                end
                ST_GAP: begin
                    state_reg <= ST_ACCESS;
                    cnt_reg   <= base_for(cur_area_reg, cur_ext_reg,
                                          access_state_select_register_reg[cur_area_reg],
                                          area0_burst_rom_select, burst_cycle_length_select);
                end
                ST_ACCESS: begin
                    if (cnt_reg != 2'h0) begin
                        cnt_reg <= cnt_reg - 2'h1;
                    end else if (cur_waits != 2'h0) begin
                        state_reg <= ST_WAIT;
                        cnt_reg   <= cur_waits - 2'h1; // R14
                    end else begin
                        state_reg         <= ST_READY;
                        done_reg          <= 1'b1;
                        prev_ext_read_reg <= cur_ext_reg && !cur_write_reg;
                        prev_area_reg     <= cur_area_reg;
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg != 2'h0) begin
                        cnt_reg <= cnt_reg - 2'h1; // R14
                    end else begin
                        state_reg         <= ST_READY;
                        done_reg          <= 1'b1;
                        prev_ext_read_reg <= cur_ext_reg && !cur_write_reg;
                        prev_area_reg     <= cur_area_reg;
                    end
                end
            endcase
        end
    end

    assign ACC_DONE          = done_reg;
    assign IDLE_STATE        = (state_reg == ST_GAP);
    assign WAIT_STATE        = (state_reg == ST_WAIT);
    assign BURST_ROM_SEL     = area0_burst_rom_select; // R11
    assign BURST_CYCLE_TWO   = burst_cycle_length_select; // R12
    assign BURST_EIGHT_WORDS = burst_word_count_select; // R12

    // Write path: address and data taken in either order
    assign S_AXI_AWREADY = !aw_hold_reg && !bvalid_reg;
    assign S_AXI_WREADY  = !w_hold_reg && !bvalid_reg;
    assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_hit        = (aw_addr_reg == OFF_UPPER_WAIT) || (aw_addr_reg == OFF_LOWER_WAIT) ||
                           (aw_addr_reg == OFF_IDLE_CTRL) || (aw_addr_reg == OFF_ACC_STATE) ||
                           (aw_addr_reg == OFF_STATUS);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_strb0_reg <= 1'b0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= S_AXI_WDATA[7:0];
            w_strb0_reg <= S_AXI_WSTRB[0];
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP  = bresp_reg;

    // Only byte lane 0 carries register data
    always_ff @(posedge MCLK) begin
        if (hw_init) begin
            upper_area_wait_count_reg <= RST_UPPER_WAIT; // R5
            lower_area_wait_count_reg <= RST_LOWER_WAIT; // R5
        end else if (do_write && w_strb0_reg) begin
            if (aw_addr_reg == OFF_UPPER_WAIT) begin
                upper_area_wait_count_reg <= w_data_reg; // R2
            end
            if (aw_addr_reg == OFF_LOWER_WAIT) begin
                lower_area_wait_count_reg <= w_data_reg; // R3
            end
        end
    end

    // Not touched by manual reset or software standby
    always_ff @(posedge MCLK) begin
        if (hw_init) begin
            idle_and_area0_interface_control_reg <= RST_IDLE_CTRL; // R6 R7
        end else if (do_write && w_strb0_reg && aw_addr_reg == OFF_IDLE_CTRL) begin
            // Reserved low bits held at zero whatever is written
            idle_and_area0_interface_control_reg <= w_data_reg & IDLE_CTRL_MASK; // R13
        end
    end

    always_ff @(posedge MCLK) begin
        if (hw_init) begin
            access_state_select_register_reg <= RST_ACC_STATE;
        end else if (do_write && w_strb0_reg && aw_addr_reg == OFF_ACC_STATE) begin
            access_state_select_register_reg <= w_data_reg;
        end
    end

    // Read path: one read at a time, answered the next cycle
    assign S_AXI_ARREADY = !rvalid_reg;
    assign rd_take       = S_AXI_ARVALID && S_AXI_ARREADY;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 8'h00;
        unique case ({S_AXI_ARADDR[7:2], 2'b00})
            OFF_UPPER_WAIT: rd_word = upper_area_wait_count_reg;
            OFF_LOWER_WAIT: rd_word = lower_area_wait_count_reg;
            OFF_IDLE_CTRL:  rd_word = idle_and_area0_interface_control_reg;
            OFF_ACC_STATE:  rd_word = access_state_select_register_reg;
            OFF_STATUS: begin
                rd_word[STAT_BUSY_BIT]               = (state_reg != ST_READY);
                rd_word[STAT_AREA_LSB +: 3]          = cur_area_reg;
                rd_word[STAT_PREVRD_BIT]             = prev_ext_read_reg;
                rd_word[STAT_WAIT_LSB +: 2]          = cur_waits;
                rd_word[STAT_GAP_BIT]                = (state_reg == ST_GAP);
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= {24'h00_0000, rd_word};
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP  = rresp_reg;
    assign S_AXI_RDATA  = rdata_reg;

endmodule

// ### ewc_checker.sv
// Concurrent checks on the wait and idle configuration block ports
`timescale 1ns/1ns
module ewc_checker
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RESET,
    // Register bus
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    // Access port and state
    input wire logic        ACC_VALID,
    input wire logic        ACC_READY,
    input wire logic        ACC_EXTERNAL,
    input wire logic        ACC_DONE,
    input wire logic        IDLE_STATE,
    input wire logic        WAIT_STATE,
    input wire logic        BURST_ROM_SEL,
    input wire logic        BURST_CYCLE_TWO,
    input wire logic        BURST_EIGHT_WORDS
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    sequence s_take_int; ACC_VALID && ACC_READY && !ACC_EXTERNAL; endsequence
    sequence s_wait_end; WAIT_STATE ##1 !WAIT_STATE; endsequence

    property p_burst_rst; $fell(RESET) |-> !BURST_ROM_SEL && BURST_CYCLE_TWO && !BURST_EIGHT_WORDS; endproperty
    property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    property p_rd_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    property p_wr_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    property p_wr_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    property p_idle_one; IDLE_STATE |=> !IDLE_STATE && !ACC_READY; endproperty
    property p_wait_max; WAIT_STATE [*3] |=> !WAIT_STATE; endproperty
    property p_int_done; s_take_int |-> ##2 ACC_DONE; endproperty
    property p_wait_done; s_wait_end |-> ACC_DONE; endproperty
    property p_wait_busy; WAIT_STATE |-> !ACC_READY && !ACC_DONE; endproperty

    a_burst_rst: assert property (p_burst_rst) else $error("area-0 outputs wrong after reset");
    a_rd_answer: assert property (p_rd_answer) else $error("read data not returned next cycle");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before ready");
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped before ready");
    a_wr_busy: assert property (p_wr_busy) else $error("write channel ready while response pending");
    a_idle_one: assert property (p_idle_one) else $error("idle state not exactly one cycle");
    a_wait_max: assert property (p_wait_max) else $error("more than three wait states");
    a_int_done: assert property (p_int_done) else $error("internal access not one state");
    a_wait_done: assert property (p_wait_done) else $error("access not completed after waits");
    a_wait_busy: assert property (p_wait_busy) else $error("ready or done during a wait state");
endmodule

bind ewc_top ewc_checker ewc_checker_i (.*);

// ### ewc_acc_master.sv
// Internal bus master model issuing timed external and internal accesses
`timescale 1ns/1ns
module ewc_acc_master
(
    // Clock
    input  wire logic  mclk,
    // Access request
    output logic       acc_valid,
    input  wire logic  acc_ready,
    output logic [2:0] acc_area,
    output logic       acc_write,
    output logic       acc_external,
    input  wire logic  acc_done
);
    initial {acc_valid, acc_area, acc_write, acc_external} = 6'h00;

    // States from the take edge until the completion pulse shows
    task automatic run(input logic [2:0] area, input logic wr, input logic ext, output int lat);
        @(posedge mclk);
        acc_valid <= 1'b1;
        acc_area <= area;
        acc_write <= wr;
        acc_external <= ext;
        do @(posedge mclk); while (acc_ready !== 1'b1);
        acc_valid <= 1'b0;
        // Released payload flips so a late sample cannot match by luck
        acc_area <= ~area;
        acc_write <= ~wr;
        acc_external <= ~ext;
        lat = 0;
        do begin
            @(posedge mclk);
            lat++;
            #1;
        end while (acc_done !== 1'b1 && lat < 40);
    endtask
endmodule

// ### test_external_area_wait_idle_config.sv
// Self-checking bench for the wait and idle configuration block
`timescale 1ns/1ns
module test_external_area_wait_idle_config import ewc_pkg::*;;
    logic        mclk, reset, hw_standby_n, manual_reset, sw_standby;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, rsp;
    logic        acc_valid, acc_ready, acc_write, acc_external, acc_done;
    logic [2:0]  acc_area;
    logic        idle_state, wait_state, brom, bcyc2, bw8;
    int          err_total, cmp_count, lat;

    ewc_top ewc_top_i (.MCLK(mclk), .RESET(reset), .HW_STANDBY_N(hw_standby_n), .MANUAL_RESET(manual_reset),
        .SW_STANDBY(sw_standby), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ACC_VALID(acc_valid), .ACC_READY(acc_ready), .ACC_AREA(acc_area), .ACC_WRITE(acc_write),
        .ACC_EXTERNAL(acc_external), .ACC_DONE(acc_done), .IDLE_STATE(idle_state), .WAIT_STATE(wait_state),
        .BURST_ROM_SEL(brom), .BURST_CYCLE_TWO(bcyc2), .BURST_EIGHT_WORDS(bw8));

    ewc_acc_master ewc_acc_master_i (.mclk(mclk), .acc_valid(acc_valid), .acc_ready(acc_ready),
        .acc_area(acc_area), .acc_write(acc_write), .acc_external(acc_external), .acc_done(acc_done));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rsp);
        chk("write response", rsp, RESP_OKAY);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rd_v, rsp);
        chk("register value", rd_v, {24'h0000_00, exp});
        chk("read response", rsp, RESP_OKAY);
    endtask

    task automatic acc(input logic [2:0] a, input logic w, input logic e, input int exp);
        ewc_acc_master_i.run(a, w, e, lat);
        chk("access states", lat, exp);
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        give_verdict;
    end

    initial begin
        {reset, hw_standby_n, manual_reset, sw_standby} = 4'hC;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0000_0000, 4'h1};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        err_total = 0;
        cmp_count = 0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        reg_chk(OFF_UPPER_WAIT, 8'hFF);
        reg_chk(OFF_LOWER_WAIT, 8'hFF);
        reg_chk(OFF_IDLE_CTRL, 8'hD0);
        chk("area-0 outputs", {brom, bcyc2, bw8}, 3'h2);
        $display("reset values test done");
        wreg(OFF_UPPER_WAIT, 32'h0000_001B);
        reg_chk(OFF_UPPER_WAIT, 8'h1B);
        wreg(OFF_LOWER_WAIT, 32'h0000_00E4);
        reg_chk(OFF_LOWER_WAIT, 8'hE4);
        wreg(OFF_IDLE_CTRL, 32'h0000_00F8);
        reg_chk(OFF_IDLE_CTRL, 8'hF8);
        chk("area-0 outputs", {brom, bcyc2, bw8}, 3'h7);
        wr(8'h20, 32'h0000_0000, rsp);
        chk("unmapped write response", rsp, RESP_SLVERR);
        rd(8'h20, rd_v, rsp);
        chk("unmapped read response", rsp, RESP_SLVERR);
        wstrb <= 4'h0;
        wreg(OFF_UPPER_WAIT, 32'h0000_0000);
        wstrb <= 4'h1;
        reg_chk(OFF_UPPER_WAIT, 8'h1B);
        $display("register access test done");
        wreg(OFF_IDLE_CTRL, 32'h0000_0000);
        for (int a = 0; a < 8; a++)
            acc(a[2:0], 1'b0, 1'b1, 3 + (((a < 4 ? 8'hE4 : 8'h1B) >> (2 * (a % 4))) & 3));
        wreg(OFF_ACC_STATE, 32'h0000_0008);
        acc(3'h3, 1'b0, 1'b1, 6);
        acc(3'h2, 1'b0, 1'b1, 2);
        acc(3'h3, 1'b0, 1'b0, 1);
        acc(3'h3, 1'b1, 1'b1, 6);
        $display("wait state test done");
        wreg(OFF_ACC_STATE, 32'h0000_0000);
        wreg(OFF_IDLE_CTRL, 32'h0000_00C0);
        acc(3'h1, 1'b0, 1'b1, 2);
        acc(3'h2, 1'b0, 1'b1, 3);
        acc(3'h2, 1'b0, 1'b1, 2);
        acc(3'h2, 1'b1, 1'b1, 3);
        acc(3'h1, 1'b0, 1'b0, 1);
        acc(3'h1, 1'b1, 1'b1, 2);
        wreg(OFF_IDLE_CTRL, 32'h0000_0040);
        acc(3'h1, 1'b0, 1'b1, 2);
        acc(3'h2, 1'b0, 1'b1, 2);
        acc(3'h2, 1'b1, 1'b1, 3);
        wreg(OFF_IDLE_CTRL, 32'h0000_0000);
        acc(3'h2, 1'b0, 1'b1, 2);
        acc(3'h2, 1'b1, 1'b1, 2);
        wreg(OFF_ACC_STATE, 32'h0000_00FF);
        wreg(OFF_IDLE_CTRL, 32'h0000_0020);
        acc(3'h0, 1'b0, 1'b1, 1);
        wreg(OFF_IDLE_CTRL, 32'h0000_0030);
        acc(3'h0, 1'b0, 1'b1, 2);
        reg_chk(OFF_STATUS, 8'h10);
        $display("idle and burst test done");
        wreg(OFF_IDLE_CTRL, 32'h0000_0098);
        manual_reset <= 1'b1;
        repeat (4) @(posedge mclk);
        manual_reset <= 1'b0;
        sw_standby <= 1'b1;
        repeat (4) @(posedge mclk);
        sw_standby <= 1'b0;
        repeat (4) @(posedge mclk);
        reg_chk(OFF_IDLE_CTRL, 8'h98);
        acc(3'h5, 1'b0, 1'b0, 1);
        @(posedge mclk) hw_standby_n <= 1'b0;
        repeat (4) @(posedge mclk);
        hw_standby_n <= 1'b1;
        repeat (4) @(posedge mclk);
        reg_chk(OFF_IDLE_CTRL, 8'hD0);
        reg_chk(OFF_LOWER_WAIT, 8'hFF);
        $display("standby test done");
        give_verdict;
    end
endmodule
